// ==== verification/i2c_bus_model.sv ====
// Purpose: behavioural two-wire bus master facing the slave engine
// Assumes: open-drain lines with pull-ups, 160 ns bit time
// Notes: a held clock line stalls it; the bench watchdog ends a hang
`timescale 1ns/100ps
`default_nettype none
module i2c_bus_model (
  output var logic sda_low,
  output var logic scl_low,
  input  wire logic sda,
  input  wire logic scl
);
  initial
  begin
    sda_low = 0;
    scl_low = 0;
  end
  task automatic bit_x(input logic b, output logic r);
    sda_low = !b;
    #80;
    scl_low = 0;
    wait (scl === 1'b1);
    #20;
    r = sda;
    #20;
    scl_low = 1;
    #40;
  endtask
  task automatic start();
    sda_low = 1;
    #80;
    scl_low = 1;
    #40;
  endtask
  task automatic stop();
    sda_low = 1;
    #40;
    scl_low = 0;
    wait (scl === 1'b1);
    #80;
    sda_low = 0;
    #80;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
                       output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(last, ack);
  endtask
endmodule // i2c_bus_model
`default_nettype wire

// ==== verification/i2c_ctl_props.sv ====
// Purpose: port checks for the two-wire control block
// Assumes: one aclk domain, synchronous active-low reset
// Notes: bound into every i2c_ctl instance
`timescale 1ns/100ps
`default_nettype none
module i2c_ctl_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic [3:0]  port_pin_out,
  input wire logic [3:0]  port_pin_oe_n,
  input wire logic        slew_control_on,
  input wire logic        read_done_flag,
  input wire logic        write_done_flag,
  input wire logic        master_addr_acked,
  input wire logic        master_irq,
  input wire logic [1:0]  master_irq_priority,
  input wire logic        master_enable,
  input wire logic        master_stop_req,
  input wire logic        master_ack_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && s_axi_rdata[31:8] == 24'h0) else $error("read not answered");
  irq_prio_a: assert property (master_irq |-> master_irq_priority != 2'h0
    && master_enable) else $error("irq without priority");
  irq_src_a: assert property (master_irq |-> $past(read_done_flag || write_done_flag))
    else $error("irq without done flag");
  quick_stop_a: assert property (master_stop_req |-> $past(master_addr_acked)
    && master_enable) else $error("stop without address ack");
  smart_ack_a: assert property (master_ack_req |=> !master_ack_req)
    else $error("ack request not a pulse");
  normal_pins_a: assert property (slew_control_on && $stable(slew_control_on)
    && $past(aresetn) |-> port_pin_oe_n[3:2] == 2'b11 && port_pin_out[1:0] == 2'b00)
    else $error("normal mode pins wrong");
  ext_pins_a: assert property (!slew_control_on && $stable(slew_control_on)
    |-> port_pin_out[1:0] == 2'b11) else $error("external mode pins wrong");
  cover property (master_stop_req);
  cover property (master_ack_req);
  cover property (!port_pin_oe_n[1]);
endmodule // i2c_ctl_props
bind i2c_ctl i2c_ctl_props i_i2c_ctl_props (.*);
`default_nettype wire

// ==== verification/i2c_slave_and_master_control_tb_top.sv ====
// Purpose: self-checking bench for the two-wire control block
// Assumes: 100 MHz aclk, bus model on pins 0 and 1
// Notes: register cases run from a table, link cases by hand
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_and_master_control_tb_top;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, read_done_flag = 0, write_done_flag = 0;
  logic master_start_issued = 0, master_arb_lost = 0, master_addr_acked = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, master_rx_data = 8'h5C, q;
  logic [31:0] s_axi_wdata = 0, rdat;
  logic [3:0] s_axi_wstrb = 0, port_pin_in = 4'hF;
  logic [1:0] resp;
  logic ack;
  int mismatches = 0, n_checks = 0;
  wire [1:0] s_axi_bresp, s_axi_rresp, master_irq_priority, master_cmd_code;
  wire [31:0] s_axi_rdata;
  wire [3:0] port_pin_out, port_pin_oe_n;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sda_low;
  wire slew_control_on, master_irq, master_enable, master_stop_req, master_ack_req, scl_low;
  wire master_ack_value, master_cmd_req;
  wire [3:0] lvl = ~(~port_pin_oe_n & ~port_pin_out) & {2'b11, ~scl_low, ~sda_low};
  // address, value read back after writing all ones, response
  logic [17:0] rows [5] = '{{8'h00, 8'h03, 2'h0}, {8'h04, 8'hF8, 2'h0},
    {8'h08, 8'h0F, 2'h0}, {8'h0C, 8'h04, 2'h0}, {8'h3C, 8'h00, 2'h2}};
  i2c_ctl #(.TMO_50_CYC(50), .TMO_100_CYC(100), .TMO_200_CYC(200)) i_i2c_ctl (.*);
  i2c_bus_model i_i2c_bus_model (.sda_low(sda_low), .scl_low(scl_low), .sda(lvl[0]),
    .scl(lvl[1]));
  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) port_pin_in <= lvl;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rcm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 0;
    chk(rdat & {24'hFFFFFF, m}, {24'h0, e});
  endtask
  initial
  begin
    #200000;
    mismatches++;
    stop_test();
  end
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    foreach (rows[i])
    begin
      rcm(rows[i][17:10], 8'hFF, 8'h00);
      chk(resp, rows[i][1:0]);
      wr(rows[i][17:10], 8'hFF);
      chk(resp, rows[i][1:0]);
      rcm(rows[i][17:10], 8'hFF, rows[i][9:2]);
    end
    wr(8'h00, 8'h00);
    #1 chk(slew_control_on, 1);
    rcm(8'h10, 8'h03, 8'h00);
    rcm(8'h14, 8'hFF, 8'h5C);
    chk({master_ack_value, master_cmd_code}, 3'h7);
    read_done_flag <= 1;
    repeat (3) @(posedge aclk);
    chk(master_irq, 1);
    wr(8'h04, 8'h38);
    repeat (3) @(posedge aclk);
    chk(master_irq, 0);
    master_addr_acked <= 1;
    @(posedge aclk);
    master_addr_acked <= 0;
    #1 chk(master_stop_req, 1);
    wr(8'h10, 8'h01);
    rcm(8'h10, 8'h03, 8'h01);
    wr(8'h20, 8'hB4);
    wr(8'h18, 8'h01);
    wr(8'h08, 8'h04);
    i_i2c_bus_model.start();
    rcm(8'h10, 8'h03, 8'h03);
    repeat (80) @(posedge aclk);
    rcm(8'h10, 8'h03, 8'h01);
    i_i2c_bus_model.stop();
    rcm(8'h1C, 8'h04, 8'h04);
    wr(8'h1C, 8'h0C);
    i_i2c_bus_model.start();
    i_i2c_bus_model.xbyte(8'hB4, 1, q, ack);
    chk(ack, 0);
    repeat (20) @(posedge aclk);
    // the model parks scl low too, so the line level says nothing here
    chk(port_pin_oe_n[1], 0);
    rcm(8'h1C, 8'hE2, 8'h60);
    wr(8'h1C, 8'h40);
    repeat (10) @(posedge aclk);
    chk(port_pin_oe_n[1], 1);
    fork
      i_i2c_bus_model.xbyte(8'hA5, 1, q, ack);
      begin
        repeat (150) @(posedge aclk);
        rcm(8'h1C, 8'h80, 8'h80);
        rcm(8'h24, 8'hFF, 8'hA5);
        wr(8'h1C, 8'h80);
      end
    join
    chk(ack, 0);
    i_i2c_bus_model.stop();
    rcm(8'h1C, 8'h41, 8'h41);
    wr(8'h1C, 8'hC1);
    i_i2c_bus_model.start();
    i_i2c_bus_model.xbyte(8'hB6, 1, q, ack);
    chk(ack, 1);
    rcm(8'h1C, 8'h40, 8'h00);
    i_i2c_bus_model.stop();
    i_i2c_bus_model.start();
    i_i2c_bus_model.xbyte(8'hB5, 1, q, ack);
    chk(ack, 0);
    repeat (20) @(posedge aclk);
    rcm(8'h1C, 8'hC2, 8'hC2);
    wr(8'h1C, 8'h40);
    wr(8'h24, 8'h3C);
    i_i2c_bus_model.xbyte(8'hFF, 1, q, ack);
    chk(q, 8'h3C);
    repeat (20) @(posedge aclk);
    rcm(8'h1C, 8'h90, 8'h90);
    wr(8'h1C, 8'h80);
    i_i2c_bus_model.stop();
    stop_test();
  end
endmodule // i2c_slave_and_master_control_tb_top
`default_nettype wire

// ==== verilog/i2c_ctl.v ====
// Purpose: two-wire slave engine, pin mux and master control registers
// Assumes: one 100 MHz clock; pins sampled through two flip-flops
// Notes: master byte engine sits outside and talks over strobes
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "i2c_ctl_regs.vh"
module i2c_ctl #(
  parameter TMO_50_CYC  = `TMO_50_NS / `CLK_PERIOD_NS,
  parameter TMO_100_CYC = `TMO_100_NS / `CLK_PERIOD_NS,
  parameter TMO_200_CYC = `TMO_200_NS / `CLK_PERIOD_NS
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [3:0]  port_pin_in,
  output reg  [3:0]  port_pin_out,
  output reg  [3:0]  port_pin_oe_n,
  output reg         slew_control_on,
  input  wire        read_done_flag,
  input  wire        write_done_flag,
  input  wire        master_start_issued,
  input  wire        master_arb_lost,
  input  wire        master_addr_acked,
  input  wire [7:0]  master_rx_data,
  output reg         master_irq,
  output reg  [1:0]  master_irq_priority,
  output reg         master_enable,
  output reg         master_stop_req,
  output reg         master_ack_req,
  output reg         master_ack_value,
  output reg         master_cmd_req,
  output reg  [1:0]  master_cmd_code
);
  localparam S_IDLE = 8'h01;
  localparam S_ADDR = 8'h02;
  localparam S_AACK = 8'h04;
  localparam S_RX   = 8'h08;
  localparam S_DACK = 8'h10;
  localparam S_TX   = 8'h20;
  localparam S_TACK = 8'h40;
  localparam S_WAIT = 8'h80;

  // register bus
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg         aw_full_q;
  reg         w_full_q;
  reg         w_lane_q;
  wire        wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire        wr_ok;
  wire        rd_go = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready  = ~w_full_q;
  assign s_axi_arready = ~s_axi_rvalid;

  reg  [7:0]  common_q;
  reg  [7:0]  mirq_q;
  reg  [7:0]  mtmo_q;
  reg         ack_sel_q;
  reg  [1:0]  bus_state_q;
  reg  [2:0]  slv_ctrl_q;
  reg  [6:0]  slv_addr_q;
  reg  [3:0]  port_dir_q;

  // slave state
  reg  [7:0]  state_q;
  reg  [3:0]  cnt_q;
  reg  [7:0]  shift_q;
  reg  [7:0]  rx_byte_q;
  reg         data_flag_q;
  reg         as_flag_q;
  reg         stop_seen_q;
  reg         coll_q;
  reg         berr_q;
  reg         dir_q;
  reg         rxack_q;
  reg         selected_q;
  reg         sda_want_q;
  reg         sda_low_q;
  reg         scl_low_q;
  reg  [4:0]  hold_cnt_q;

  wire ext_mode = common_q[`BIT_EXT_DRV];
  wire [7:0] wb = w_data_q[7:0];
  wire wr_lane  = wr_go & w_lane_q;

  // pin synchronisers and filter
  reg  [1:0]  sda_sync_q;
  reg  [1:0]  scl_sync_q;
  reg  [`FILT_LEN-1:0] sda_hist_q;
  reg  [`FILT_LEN-1:0] scl_hist_q;
  reg         sda_f_q;
  reg         scl_f_q;
  reg         sda_p_q;
  reg         scl_p_q;
  wire        sda_pin = port_pin_in[0];
  wire        scl_pin = port_pin_in[1];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sda_sync_q <= 2'h3;
      scl_sync_q <= 2'h3;
      sda_hist_q <= {`FILT_LEN{1'b1}};
      scl_hist_q <= {`FILT_LEN{1'b1}};
      sda_f_q    <= 1'b1;
      scl_f_q    <= 1'b1;
      sda_p_q    <= 1'b1;
      scl_p_q    <= 1'b1;
    end
    else
    begin
      sda_sync_q <= {sda_sync_q[0], sda_pin};
      scl_sync_q <= {scl_sync_q[0], scl_pin};
      sda_hist_q <= {sda_hist_q[`FILT_LEN-2:0], sda_sync_q[1]};
      scl_hist_q <= {scl_hist_q[`FILT_LEN-2:0], scl_sync_q[1]};
      // filter only in normal mode; external drivers take raw levels
      if (ext_mode)
      begin
        sda_f_q <= sda_sync_q[1];
        scl_f_q <= scl_sync_q[1];
      end
      else
      begin
        if (&sda_hist_q | ~|sda_hist_q)
          sda_f_q <= sda_hist_q[0];
        if (&scl_hist_q | ~|scl_hist_q)
          scl_f_q <= scl_hist_q[0];
      end
      sda_p_q <= sda_f_q;
      scl_p_q <= scl_f_q;
    end
  end

  wire scl_rise = scl_f_q & ~scl_p_q;
  wire scl_fall = ~scl_f_q & scl_p_q;
  wire start_ev = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
  wire stop_ev  = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

  // software clear events, set wins below
  wire st_wr     = wr_lane & aw_addr_q == `OFS_SLAVE_STAT;
  wire dat_wr    = wr_lane & aw_addr_q == `OFS_SLAVE_DATA;
  wire clr_data  = (st_wr & wb[7]) | (dat_wr & state_q == S_TX & data_flag_q);
  wire clr_as    = st_wr & wb[6];
  wire slv_en    = slv_ctrl_q[0];
  wire promisc   = slv_ctrl_q[1];
  wire addr_hit  = shift_q[7:1] == slv_addr_q | shift_q[7:1] == 7'h00 | promisc;

  reg        set_data;
  reg        set_as;
  reg        set_coll;
  reg        set_berr;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q     <= S_IDLE;
      cnt_q       <= 4'h0;
      shift_q     <= 8'h00;
      rx_byte_q   <= 8'h00;
      dir_q       <= 1'b0;
      rxack_q     <= 1'b0;
      selected_q  <= 1'b0;
      stop_seen_q <= 1'b0;
      sda_want_q  <= 1'b0;
      set_data    <= 1'b0;
      set_as      <= 1'b0;
      set_coll    <= 1'b0;
      set_berr    <= 1'b0;
    end
    else
    begin
      set_data <= 1'b0;
      set_as   <= 1'b0;
      set_coll <= 1'b0;
      set_berr <= 1'b0;
      if (!slv_en)
      begin
        state_q    <= S_IDLE;
        sda_want_q <= 1'b0;
        selected_q <= 1'b0;
      end
      else if (start_ev)
      begin
        state_q    <= S_ADDR;
        cnt_q      <= 4'h0;
        sda_want_q <= 1'b0;
        selected_q <= 1'b0;
      end
      else if (stop_ev)
      begin
        if (state_q == S_ADDR)
          set_berr <= 1'b1;
        else if (selected_q)
        begin
          set_as      <= 1'b1;
          stop_seen_q <= 1'b1;
        end
        state_q    <= S_IDLE;
        sda_want_q <= 1'b0;
        selected_q <= 1'b0;
      end
      else
      begin
        case (state_q)
          S_ADDR:
          begin
            if (scl_rise)
            begin
              shift_q <= {shift_q[6:0], sda_f_q};
              cnt_q   <= cnt_q + 4'h1;
            end
            else if (scl_fall && cnt_q == 4'h8)
            begin
              if (addr_hit)
              begin
                state_q    <= S_AACK;
                sda_want_q <= 1'b1;
              end
              else
                state_q <= S_WAIT;
            end
          end
          S_AACK:
            if (scl_fall)
            begin
              sda_want_q  <= 1'b0;
              set_as      <= 1'b1;
              stop_seen_q <= 1'b0;
              dir_q       <= shift_q[0];
              selected_q  <= 1'b1;
              cnt_q       <= 4'h0;
              if (shift_q[0])
              begin
                state_q  <= S_TX;
                set_data <= 1'b1;
              end
              else
                state_q <= S_RX;
            end
          S_RX:
          begin
            if (scl_rise)
            begin
              shift_q <= {shift_q[6:0], sda_f_q};
              cnt_q   <= cnt_q + 4'h1;
            end
            else if (scl_fall && cnt_q == 4'h8)
            begin
              rx_byte_q <= shift_q;
              set_data  <= 1'b1;
              state_q   <= S_DACK;
            end
          end
          S_DACK:
          begin
            // ack goes out only once software clears the data flag
            if (clr_data && data_flag_q)
              sda_want_q <= ~slv_ctrl_q[2];
            else if (scl_fall && !data_flag_q)
            begin
              sda_want_q <= 1'b0;
              cnt_q      <= 4'h0;
              state_q    <= slv_ctrl_q[2] ? S_WAIT : S_RX;
            end
          end
          S_TX:
          begin
            if (dat_wr && data_flag_q && cnt_q == 4'h0)
            begin
              shift_q    <= wb;
              sda_want_q <= ~wb[7];
            end
            else if (scl_rise)
            begin
              cnt_q <= cnt_q + 4'h1;
              if (!sda_want_q && !sda_f_q)
              begin
                set_coll   <= 1'b1;
                sda_want_q <= 1'b0;
                state_q    <= S_WAIT;
              end
            end
            else if (scl_fall && cnt_q == 4'h8)
            begin
              sda_want_q <= 1'b0;
              state_q    <= S_TACK;
            end
            else if (scl_fall && cnt_q != 4'h0)
            begin
              shift_q    <= {shift_q[6:0], 1'b0};
              sda_want_q <= ~shift_q[6];
            end
          end
          S_TACK:
          begin
            if (scl_rise)
              rxack_q <= sda_f_q;
            else if (scl_fall)
            begin
              set_data <= 1'b1;
              cnt_q    <= 4'h0;
              state_q  <= rxack_q ? S_WAIT : S_TX;
            end
          end
          S_WAIT:
            sda_want_q <= 1'b0;
          S_IDLE:
            sda_want_q <= 1'b0;
          default:
            state_q <= S_IDLE;
        endcase
      end
    end
  end

  // flags: a set in the same cycle as a clear wins
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      data_flag_q <= 1'b0;
      as_flag_q   <= 1'b0;
      coll_q      <= 1'b0;
      berr_q      <= 1'b0;
    end
    else
    begin
      data_flag_q <= set_data | (data_flag_q & ~clr_data);
      as_flag_q   <= set_as | (as_flag_q & ~clr_as);
      coll_q      <= set_coll | (coll_q & ~(st_wr & wb[3]));
      berr_q      <= set_berr | (berr_q & ~(st_wr & wb[2]));
    end
  end

  // clock stretch and data hold
  wire stretch = data_flag_q | (as_flag_q & ~stop_seen_q);
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hold_cnt_q <= 5'h00;
      sda_low_q  <= 1'b0;
      scl_low_q  <= 1'b0;
    end
    else
    begin
      if (scl_fall && common_q[`BIT_SDA_HOLD])
        hold_cnt_q <= `SDA_HOLD_CYC;
      else if (hold_cnt_q != 5'h00)
        hold_cnt_q <= hold_cnt_q - 5'h01;
      if (hold_cnt_q == 5'h00 && !(scl_fall && common_q[`BIT_SDA_HOLD]))
        sda_low_q <= sda_want_q & ~coll_q;
      scl_low_q <= stretch & ~scl_f_q;
    end
  end

  // pin mux; oe_n low means driving
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_pin_out    <= 4'hF;
      port_pin_oe_n   <= 4'hF;
      slew_control_on <= 1'b1;
    end
    else if (ext_mode)
    begin
      port_pin_out    <= {~scl_low_q, ~sda_low_q, 2'h3};
      port_pin_oe_n   <= ~port_dir_q;
      slew_control_on <= 1'b0;
    end
    else
    begin
      port_pin_out    <= 4'h0;
      port_pin_oe_n   <= {2'h3, ~scl_low_q, ~sda_low_q};
      slew_control_on <= 1'b1;
    end
  end

  // bus state and inactivity timeout
  reg  [15:0] idle_cnt_q;
  reg  [15:0] tmo_lim;
  always @*
  begin
    case (mtmo_q[3:2])
      2'h1:    tmo_lim = TMO_50_CYC[15:0];
      2'h2:    tmo_lim = TMO_100_CYC[15:0];
      2'h3:    tmo_lim = TMO_200_CYC[15:0];
      default: tmo_lim = 16'h0000;
    endcase
  end
  wire line_act = scl_rise | scl_fall | (sda_f_q ^ sda_p_q);
  wire tmo_hit  = mtmo_q[3:2] != 2'h0 && idle_cnt_q >= tmo_lim;
  wire men      = mirq_q[`BIT_MEN];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      idle_cnt_q  <= 16'h0000;
      bus_state_q <= `BS_UNKNOWN;
    end
    else
    begin
      if (line_act || tmo_hit)
        idle_cnt_q <= 16'h0000;
      else if (idle_cnt_q != 16'hFFFF)
        idle_cnt_q <= idle_cnt_q + 16'h0001;
      if (!men)
        bus_state_q <= `BS_UNKNOWN;
      else if (wr_lane && aw_addr_q == `OFS_MASTER_STAT && wb[1:0] == `BS_IDLE)
        bus_state_q <= `BS_IDLE;
      else if (bus_state_q != `BS_UNKNOWN || stop_ev)
      begin
        if (stop_ev || (tmo_hit && bus_state_q != `BS_IDLE))
          bus_state_q <= `BS_IDLE;
        else if (master_arb_lost)
          bus_state_q <= `BS_BUSY;
        else if (bus_state_q == `BS_IDLE && master_start_issued)
          bus_state_q <= `BS_OWNER;
        else if (bus_state_q == `BS_IDLE && start_ev)
          bus_state_q <= `BS_BUSY;
      end
    end
  end

  // master strobes
  wire mdata_rd = rd_go && s_axi_araddr == `OFS_MASTER_DATA;
  wire cmd_wr   = wr_lane && aw_addr_q == `OFS_MASTER_CMD;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      master_irq          <= 1'b0;
      master_irq_priority <= 2'h0;
      master_enable       <= 1'b0;
      master_stop_req     <= 1'b0;
      master_ack_req      <= 1'b0;
      master_ack_value    <= 1'b0;
      master_cmd_req      <= 1'b0;
      master_cmd_code     <= 2'h0;
    end
    else
    begin
      master_irq <= mirq_q[7:6] != 2'h0 && men &&
                    ((read_done_flag & mirq_q[`BIT_READ_IRQ_ENABLE]) |
                     (write_done_flag & mirq_q[`BIT_WRITE_IRQ_ENABLE]));
      master_irq_priority <= mirq_q[7:6];
      master_enable       <= men;
      master_stop_req     <= men & mtmo_q[`BIT_QUICK_COMMAND_ENABLE] & master_addr_acked;
      master_ack_req      <= men & mtmo_q[`BIT_AUTO_ACK_ON_READ_ENABLE] & mdata_rd;
      master_cmd_req      <= men & cmd_wr & wb[1:0] != 2'h0;
      // new ack select takes effect with a command written alongside it
      if (cmd_wr)
      begin
        master_ack_value <= wb[`BIT_ACK_SEL];
        master_cmd_code  <= wb[1:0];
      end
      else if (mdata_rd)
        master_ack_value <= ack_sel_q;
    end
  end

  // register writes
  assign wr_ok = aw_addr_q <= `OFS_PORT_DIR && aw_addr_q[1:0] == 2'h0;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q    <= 1'b0;
      w_full_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0000_0000;
      w_lane_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      common_q     <= `RST_BYTE;
      mirq_q       <= `RST_BYTE;
      mtmo_q       <= `RST_BYTE;
      ack_sel_q    <= 1'b0;
      slv_ctrl_q   <= 3'h0;
      slv_addr_q   <= 7'h00;
      port_dir_q   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_q)
      begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_lane_q <= s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        // reserved bits are kept at zero regardless of what arrives
        if (w_lane_q)
          case (aw_addr_q)
            `OFS_COMMON_CTRL: common_q   <= {6'h00, wb[1:0]};
            `OFS_MASTER_IRQ:  mirq_q     <= {wb[7:3], 3'h0};
            `OFS_MASTER_TMO:  mtmo_q     <= {4'h0, wb[3:0]};
            `OFS_MASTER_CMD:  ack_sel_q  <= wb[`BIT_ACK_SEL];
            `OFS_SLAVE_CTRL:  slv_ctrl_q <= wb[2:0];
            `OFS_SLAVE_ADDR:  slv_addr_q <= wb[7:1];
            `OFS_PORT_DIR:    port_dir_q <= wb[3:0];
            default:          port_dir_q <= port_dir_q;
          endcase
      end
    end
  end

  // register reads
  reg [7:0] rd_val;
  always @*
  begin
    case (s_axi_araddr)
      `OFS_COMMON_CTRL: rd_val = common_q;
      `OFS_MASTER_IRQ:  rd_val = mirq_q;
      `OFS_MASTER_TMO:  rd_val = mtmo_q;
      `OFS_MASTER_CMD:  rd_val = {5'h00, ack_sel_q, 2'h0};
      `OFS_MASTER_STAT: rd_val = {read_done_flag, write_done_flag, 4'h0, bus_state_q};
      `OFS_MASTER_DATA: rd_val = master_rx_data;
      `OFS_SLAVE_CTRL:  rd_val = {5'h00, slv_ctrl_q};
      `OFS_SLAVE_STAT:  rd_val = {data_flag_q, as_flag_q, stretch, rxack_q,
                                  coll_q, berr_q, dir_q, stop_seen_q};
      `OFS_SLAVE_ADDR:  rd_val = {slv_addr_q, 1'b0};
      `OFS_SLAVE_DATA:  rd_val = rx_byte_q;
      `OFS_PORT_DIR:    rd_val = {4'h0, port_dir_q};
      default:          rd_val = 8'h00;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_val};
      s_axi_rresp  <= (s_axi_araddr <= `OFS_PORT_DIR && s_axi_araddr[1:0] == 2'h0)
                      ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // i2c_ctl
`default_nettype wire

// ==== verilog/i2c_ctl_regs.vh ====
// Purpose: constants for the two-wire slave and master control block
// Assumes: 100 MHz aclk, 32-bit AXI4-Lite register words
// Notes: offsets are byte addresses
// Contract
// - pending slave flag holds clock line low
// - receive address after start, ack match only
// - address match or general call sets flag
// - start then stop sets bus error
// - direction flag copies received read/write bit
// - read address: stretch, ack, request transmit data
// - write address: stretch, ack, then await data
// - lost high or nack: collision, release outputs (code: collision only on a lost high data bit)
// - stop sets address/stop flag, marked stop
// - each received byte flags; software picks ack
// - data write sends byte; nack ends transmit
// - normal mode: pin0 data, pin1 clock, filtered
// - external driver mode uses pins 0..3
// - hold bit delays data after clock fall
// - priority field nonzero enables master interrupt
// - read/write enables gate done flags
// - master works only while enabled
// - timeout field forces idle after inactivity (code: only from owner or busy, not from unknown)
// - quick command stops after address ack
// - smart mode acks on data register read
// - promiscuous mode answers every address
// - ack select: 0 ack, 1 nack
// - bus state encoding; writing 01 forces idle
`ifndef I2C_CTL_REGS_VH
`define I2C_CTL_REGS_VH
`define OFS_COMMON_CTRL   8'h00
`define OFS_MASTER_IRQ    8'h04
`define OFS_MASTER_TMO    8'h08
`define OFS_MASTER_CMD    8'h0C
`define OFS_MASTER_STAT   8'h10
`define OFS_MASTER_DATA   8'h14
`define OFS_SLAVE_CTRL    8'h18
`define OFS_SLAVE_STAT    8'h1C
`define OFS_SLAVE_ADDR    8'h20
`define OFS_SLAVE_DATA    8'h24
`define OFS_PORT_DIR      8'h28
`define RST_BYTE          8'h00
`define BIT_EXT_DRV       0
`define BIT_SDA_HOLD      1
`define BIT_MEN           3
`define BIT_WRITE_IRQ_ENABLE          4
`define BIT_READ_IRQ_ENABLE          5
`define BIT_QUICK_COMMAND_ENABLE          1
`define BIT_AUTO_ACK_ON_READ_ENABLE          0
`define BIT_ACK_SEL       2
`define BS_UNKNOWN        2'h0
`define BS_IDLE           2'h1
`define BS_OWNER          2'h2
`define BS_BUSY           2'h3
`define CLK_PERIOD_NS     10
`define TMO_50_NS         50000
`define TMO_100_NS        100000
`define TMO_200_NS        200000
`define SDA_HOLD_NS       300
`define SDA_HOLD_CYC      5'h1E
`define FILT_LEN          3
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif
